// ===== pkg/afe_params.svh
// Register offsets, field positions, reset values and counts
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH
`define A_DEV 8'h00
`define A_SER1 8'h01
`define A_SER2 8'h03
`define A_BYP 8'h05
`define A_HPF 8'h06
`define A_DEEM 8'h07
`define A_STAT 8'h08
`define A_EQ0 8'h10
`define A_EQN 8'h19
`define DEV_RST 16'h0002
`define SER_RST 16'h0000
`define BYP_RST 16'h0002
`define HPF_RST 9'h000
`define DEEM_RST 2'h0
`define B_INSEL 0
`define B_AMP 1
`define B_PCM 0
`define B_W16 1
`define F_MONO 3:2
`define B_HPBP 0
`define B_EQBP 1
`define HP_SHIFT 12
`define ONE_Q 20'h1_0000
`define DE_C32 20'h0_7ec1
`define DE_C44 20'h0_647b
`define DE_C48 20'h0_5e22
`define MUTE_LAST 8'h7f
`define GAIN_ONE 8'h80
`define CNT_MAX 6'h20
`define PER_MAX 11'h7ff
`define PCM_W8 6'h08
`define PCM_W16 6'h10
`define EQ_LAST 3'h6
`endif

// ===== pkg/afe_pkg.sv
// Shared types for the audio front end
package afe_pkg;
  typedef enum logic [3:0] {
    SW_RUN = 4'b0001,
    SW_MUTE = 4'b0010,
    SW_OFF = 4'b0100,
    SW_UNMUTE = 4'b1000
  } sw_state_t;
  typedef enum logic [1:0] {
    PICK_LEFT = 2'h0,
    PICK_RIGHT = 2'h1,
    PICK_SUM = 2'h2,
    PICK_SUM_ALT = 2'h3
  } pick_t;
  typedef logic signed [23:0] smp_t;
  typedef logic signed [19:0] coef_t;
endpackage

// ===== pkg/rx_if.sv
// Decoded stereo words passed from the serial receiver
`timescale 1ns/1ps
interface rx_if;
  logic signed [15:0] left;
  logic signed [15:0] right;
  logic valid;
  logic [7:0] slots;
  modport rx (output left, output right, output valid, output slots);
  modport dsp (input left, input right, input valid, input slots);
endinterface

// ===== hw/coef_mem.sv
// Equalizer coefficient store, two words per band
`timescale 1ns/1ps
module coef_mem (
  input wire logic ref_clk,
  input wire logic ce,
  input wire logic wr,
  input wire logic [2:0] waddr,
  input wire logic whi,
  input wire logic [15:0] wdata,
  input wire logic [2:0] raddr,
  output logic [31:0] rdata_ff
);
  logic [31:0] mem_ff [0:4];
  logic [31:0] nxt_rdata;
  // Out of range reads give zero
  always_comb begin
    nxt_rdata = (raddr < 3'h5) ? mem_ff[raddr] : 32'h0000_0000;
  end
  // Word 1 in the upper half, word 2 in the lower half
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      rdata_ff <= nxt_rdata;
      if (wr && waddr < 3'h5) begin
        if (whi) begin
          mem_ff[waddr][15:0] <= wdata;
        end else begin
          mem_ff[waddr][31:16] <= wdata;
        end
      end
    end
  end
endmodule

// ===== hw/serial_rx.sv
// Serial audio receiver for I2S words and PCM multi-slot frames
`timescale 1ns/1ps
`include "afe_params.svh"
module serial_rx (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sck,
  input wire logic ws,
  input wire logic sd,
  input wire logic pcm,
  input wire logic w16,
  rx_if.rx o
);
  logic sck_d_ff, ws_d_ff, v_ff;
  logic nxt_ws_d, nxt_v;
  logic [31:0] sh_ff, nxt_sh, shn, algn;
  logic [5:0] cnt_ff, nxt_cnt, cnt1, wb;
  logic [10:0] per_ff, nxt_per;
  logic signed [15:0] l_ff, r_ff, nxt_l, nxt_r, pw;
  logic [7:0] sl_ff, nxt_sl;
  // Word assembly on each bit clock rising edge
  always_comb begin
    nxt_ws_d = ws_d_ff;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_per = per_ff;
    nxt_l = l_ff;
    nxt_r = r_ff;
    nxt_sl = sl_ff;
    nxt_v = 1'b0;
    wb = w16 ? `PCM_W16 : `PCM_W8;
    cnt1 = (cnt_ff == `CNT_MAX) ? cnt_ff : cnt_ff + 6'h01;
    shn = {sh_ff[30:0], sd};
    algn = shn << (`CNT_MAX - cnt1); // MSB first, left aligned
    pw = w16 ? shn[15:0] : {shn[7:0], 8'h00};
    if (sck && !sck_d_ff) begin
      nxt_sh = shn;
      nxt_ws_d = ws;
      nxt_cnt = cnt1;
      nxt_per = (per_ff == `PER_MAX) ? per_ff : per_ff + 11'h001;
      if (pcm) begin
        // slots from bit clocks per sync period
        if (ws && !ws_d_ff) begin
          nxt_sl = w16 ? 8'(per_ff >> 4) : 8'(per_ff >> 3);
          nxt_per = 11'h001;
          nxt_cnt = 6'h00;
        end else if (cnt1 == wb) begin
          nxt_l = pw;
        end
        // right slot taken once; two-slot frames end it on the sync bit
        if (cnt_ff != `CNT_MAX && cnt1 == {wb[4:0], 1'b0}) begin
          nxt_r = pw;
          nxt_v = 1'b1;
        end
      end else if (ws != ws_d_ff) begin
        nxt_cnt = 6'h00;
        if (ws_d_ff) begin
          nxt_r = algn[31:16];
          nxt_v = 1'b1;
        end else begin
          nxt_l = algn[31:16];
        end
      end
    end
  end
  // State registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sck_d_ff <= 1'b0;
      ws_d_ff <= 1'b0;
      v_ff <= 1'b0;
      sh_ff <= 32'h0000_0000;
      cnt_ff <= 6'h00;
      per_ff <= 11'h000;
      l_ff <= 16'h0000;
      r_ff <= 16'h0000;
      sl_ff <= 8'h00;
    end else if (ce) begin
      sck_d_ff <= sck;
      ws_d_ff <= nxt_ws_d;
      v_ff <= nxt_v;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      per_ff <= nxt_per;
      l_ff <= nxt_l;
      r_ff <= nxt_r;
      sl_ff <= nxt_sl;
    end
  end
  assign o.left = l_ff;
  assign o.right = r_ff;
  assign o.valid = v_ff;
  assign o.slots = sl_ff;
endmodule

// ===== hw/afe_top.sv
// Audio front end: input switch, mono pick, high-pass, de-emphasis, EQ
//
// Contract
// - PCM sync runs at 8 kHz; bit clock is slots times width times 8 kHz.
// - Slot count is measured as bit clocks per sync period divided by the word width.
// - Two serial inputs, one active, chosen by the input-select bit.
// - On input-select change, soft mute for 128 sample periods first.
// - After the mute, go to Off mode and swap input and clock reference.
// - Then return to amplifier mode and release the soft mute.
// - Channel pick: left, right, or left plus right halved.
// - Each input has its own channel pick, registers 01h and 03h.
// - First-order high-pass, corner from (4096 - setting)/4096.
// - High-pass setting accepts every integer 0 to 511.
// - High-pass bypassed when setting is zero or bypass bit is one.
// - De-emphasis is a first-order low-pass near 3.5 kHz.
// - De-emphasis field: 00 off by default, 01/10/11 for 32/44.1/48 kHz.
// - Equalizer is either fully bypassed or five cascaded bands.
// - Band shape set by relative centre, quality and gain.
// - Each band may cut (gain below one) or boost (gain above one).
// - Each band is a second-order Regalia-Mitra all-pass lattice.
// - Bands run in series, highest band A first, band E last.
// - Per-band scale flag: 0 gives 0 dB, 1 gives -6 dB.
// - Band coefficients come as two 16-bit words of fixed layout.
`timescale 1ns/1ps
`include "afe_params.svh"
module afe_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic bit_clk1,
  input wire logic word_select_line1,
  input wire logic serial_audio_in1,
  input wire logic bit_clk2,
  input wire logic word_select_line2,
  input wire logic serial_audio_in2,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  output logic [15:0] reg_rdata,
  output logic [15:0] audio_out,
  output logic audio_valid,
  output logic amp_on,
  output logic pll_ref_sel
);
  logic [5:0] pin_raw;
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  genvar gi;
  assign pin_raw = {serial_audio_in2, word_select_line2, bit_clk2,
                    serial_audio_in1, word_select_line1, bit_clk1};
  // Two-stage synchronisers, one per pin
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          s1_ff[gi] <= 1'b0;
          s2_ff[gi] <= 1'b0;
        end else if (ce) begin
          s1_ff[gi] <= pin_raw[gi];
          s2_ff[gi] <= s1_ff[gi];
        end
      end
    end
  endgenerate

  logic [15:0] dev_ff, ser1_ff, ser2_ff, byp_ff, rd_ff;
  logic [15:0] nxt_dev, nxt_ser1, nxt_ser2, nxt_byp, nxt_rd;
  logic [8:0] hpf_ff, nxt_hpf;
  logic [1:0] deem_ff, nxt_deem;
  logic eq_wr;
  logic [7:0] eq_off;
  logic act_ff, nxt_act;
  afe_pkg::sw_state_t st_ff, nxt_st;
  rx_if rxb ();

  // Register writes and registered read-back
  always_comb begin
    nxt_dev = dev_ff;
    nxt_ser1 = ser1_ff;
    nxt_ser2 = ser2_ff;
    nxt_byp = byp_ff;
    nxt_hpf = hpf_ff;
    nxt_deem = deem_ff;
    eq_off = reg_addr - `A_EQ0;
    eq_wr = reg_wr && reg_addr >= `A_EQ0 && reg_addr <= `A_EQN;
    if (reg_wr) begin
      if (reg_addr == `A_DEV) begin
        nxt_dev = reg_wdata;
      end else if (reg_addr == `A_SER1) begin
        nxt_ser1 = reg_wdata;
      end else if (reg_addr == `A_SER2) begin
        nxt_ser2 = reg_wdata;
      end else if (reg_addr == `A_BYP) begin
        nxt_byp = reg_wdata;
      end else if (reg_addr == `A_HPF) begin
        nxt_hpf = reg_wdata[8:0];
      end else if (reg_addr == `A_DEEM) begin
        nxt_deem = reg_wdata[1:0];
      end
    end
    if (reg_addr == `A_DEV) begin
      nxt_rd = dev_ff;
    end else if (reg_addr == `A_SER1) begin
      nxt_rd = ser1_ff;
    end else if (reg_addr == `A_SER2) begin
      nxt_rd = ser2_ff;
    end else if (reg_addr == `A_BYP) begin
      nxt_rd = byp_ff;
    end else if (reg_addr == `A_HPF) begin
      nxt_rd = {7'h00, hpf_ff};
    end else if (reg_addr == `A_DEEM) begin
      nxt_rd = {14'h0000, deem_ff};
    end else if (reg_addr == `A_STAT) begin
      nxt_rd = {3'h0, act_ff, st_ff, rxb.slots};
    end else begin
      nxt_rd = 16'h0000;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dev_ff <= `DEV_RST;
      ser1_ff <= `SER_RST;
      ser2_ff <= `SER_RST;
      byp_ff <= `BYP_RST;
      hpf_ff <= `HPF_RST;
      deem_ff <= `DEEM_RST;
      rd_ff <= 16'h0000;
    end else if (ce) begin
      dev_ff <= nxt_dev;
      ser1_ff <= nxt_ser1;
      ser2_ff <= nxt_ser2;
      byp_ff <= nxt_byp;
      hpf_ff <= nxt_hpf;
      deem_ff <= nxt_deem;
      rd_ff <= nxt_rd;
    end
  end

  logic [15:0] ser_act;
  logic [31:0] cw;
  logic [2:0] bcnt_ff, nxt_bcnt;
  assign ser_act = act_ff ? ser2_ff : ser1_ff;
  // one receiver fed from the active input
  serial_rx u_rx (
    .ref_clk (ref_clk),
    .srst (srst),
    .ce (ce),
    .sck (act_ff ? s2_ff[3] : s2_ff[0]),
    .ws (act_ff ? s2_ff[4] : s2_ff[1]),
    .sd (act_ff ? s2_ff[5] : s2_ff[2]),
    .pcm (ser_act[`B_PCM]),
    .w16 (ser_act[`B_W16]),
    .o (rxb.rx)
  );
  coef_mem u_mem (
    .ref_clk (ref_clk),
    .ce (ce),
    .wr (eq_wr),
    .waddr (eq_off[3:1]),
    .whi (eq_off[0]),
    .wdata (reg_wdata),
    .raddr (bcnt_ff),
    .rdata_ff (cw)
  );

  logic [7:0] mcnt_ff, nxt_mcnt, gain_ff, nxt_gain;
  logic amp_ff, nxt_amp;
  // Input switchover sequence
  always_comb begin
    nxt_st = st_ff;
    nxt_act = act_ff;
    nxt_mcnt = mcnt_ff;
    nxt_gain = gain_ff;
    case (st_ff)
      afe_pkg::SW_RUN: begin
        if (dev_ff[`B_INSEL] != act_ff) begin
          nxt_st = afe_pkg::SW_MUTE;
          nxt_mcnt = 8'h00;
        end
      end
      afe_pkg::SW_MUTE: begin
        if (rxb.valid) begin
          nxt_gain = gain_ff - 8'h01;
          nxt_mcnt = mcnt_ff + 8'h01;
          if (mcnt_ff == `MUTE_LAST) begin
            nxt_st = afe_pkg::SW_OFF;
          end
        end
      end
      afe_pkg::SW_OFF: begin
        nxt_act = dev_ff[`B_INSEL];
        nxt_st = afe_pkg::SW_UNMUTE;
        nxt_mcnt = 8'h00;
      end
      afe_pkg::SW_UNMUTE: begin
        if (rxb.valid) begin
          nxt_gain = gain_ff + 8'h01;
          nxt_mcnt = mcnt_ff + 8'h01;
          if (mcnt_ff == `MUTE_LAST) begin
            nxt_st = afe_pkg::SW_RUN;
          end
        end
      end
      default: begin
        nxt_st = afe_pkg::SW_RUN;
      end
    endcase
    nxt_amp = dev_ff[`B_AMP] && (nxt_st != afe_pkg::SW_OFF);
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= afe_pkg::SW_RUN;
      act_ff <= 1'b0;
      mcnt_ff <= 8'h00;
      gain_ff <= `GAIN_ONE;
      amp_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      act_ff <= nxt_act;
      mcnt_ff <= nxt_mcnt;
      gain_ff <= nxt_gain;
      amp_ff <= nxt_amp;
    end
  end

  function automatic afe_pkg::smp_t mq(input afe_pkg::coef_t c,
                                       input afe_pkg::smp_t s);
    logic signed [43:0] pr;
    pr = c * s;
    mq = pr[39:16];
  endfunction

  logic signed [15:0] mono;
  logic signed [16:0] lr_sum;
  logic signed [33:0] hp_pr;
  logic signed [43:0] de_pr;
  afe_pkg::coef_t de_c;
  afe_pkg::smp_t xin, hp_y, hp_o, de_y, hx1_ff, hy1_ff, dy1_ff;
  // Mono pick, high-pass and de-emphasis
  always_comb begin
    lr_sum = rxb.left + rxb.right;
    case (afe_pkg::pick_t'(ser_act[`F_MONO]))
      afe_pkg::PICK_LEFT: mono = rxb.left;
      afe_pkg::PICK_RIGHT: mono = rxb.right;
      default: mono = lr_sum[16:1];
    endcase
    xin = {{4{mono[15]}}, mono, 4'h0};
    hp_pr = $signed({1'b0, hpf_ff}) * hy1_ff;
    hp_y = xin - hx1_ff + hy1_ff - afe_pkg::smp_t'(hp_pr >>> `HP_SHIFT);
    hp_o = (hpf_ff == 9'h000 || byp_ff[`B_HPBP]) ? xin : hp_y;
    case (deem_ff)
      2'h1: de_c = `DE_C32;
      2'h2: de_c = `DE_C44;
      default: de_c = `DE_C48;
    endcase
    de_pr = de_c * (hp_o - dy1_ff);
    de_y = (deem_ff == 2'h0) ? hp_o :
           dy1_ff + afe_pkg::smp_t'(de_pr >>> 16);
  end

  afe_pkg::smp_t eqx_ff, nxt_eqx;
  afe_pkg::smp_t d1_ff [0:4];
  afe_pkg::smp_t d2_ff [0:4];
  afe_pkg::coef_t k0, k1, k2, k1p, k2p;
  afe_pkg::smp_t v, p, w, u, ap, hb, gx;
  logic signed [32:0] g_pr;
  logic [2:0] bs;
  logic busy_ff, nxt_busy, tick;
  logic ov_ff, nxt_ov;
  logic [15:0] out_ff, nxt_out;
  // decode both words into fixed-point coefficients
  always_comb begin
    k1p = {4'h0, cw[30:20], 5'h00} >> cw[19:16];
    k2p = {4'h0, cw[14:11], 12'h000} >> cw[10:8];
    k1 = cw[31] ? k1p - `ONE_Q : `ONE_Q - k1p;
    k2 = cw[15] ? k2p - `ONE_Q : `ONE_Q - k2p;
    k0 = {2'h0, cw[7:1], 11'h000};
    bs = (bcnt_ff != 3'h0 && bcnt_ff < `EQ_LAST) ? bcnt_ff - 3'h1 : 3'h0;
    // nested lattice, inner k2, outer k1
    v = d1_ff[bs];
    p = v - mq(k2, d2_ff[bs]);
    w = mq(k2, p) + d2_ff[bs];
    u = eqx_ff - mq(k1, w);
    ap = mq(k1, u) + w;
    hb = ((eqx_ff + ap) >>> 1) + (mq(k0, eqx_ff - ap) >>> 1);
    if (cw[0]) begin
      hb = hb >>> 1;
    end
    g_pr = eqx_ff * $signed({1'b0, gain_ff});
    gx = afe_pkg::smp_t'(g_pr >>> 7);
  end
  // Per-sample sequence through the five bands
  always_comb begin
    tick = rxb.valid && !busy_ff;
    nxt_busy = busy_ff;
    nxt_bcnt = bcnt_ff;
    nxt_eqx = eqx_ff;
    nxt_out = out_ff;
    nxt_ov = 1'b0;
    if (tick) begin
      nxt_busy = 1'b1;
      nxt_bcnt = 3'h0;
      nxt_eqx = de_y;
    end else if (busy_ff) begin
      if (bcnt_ff == `EQ_LAST) begin
        nxt_busy = 1'b0;
        nxt_ov = 1'b1;
        if (gx[23:19] != {5{gx[23]}}) begin
          nxt_out = {gx[23], {15{~gx[23]}}};
        end else begin
          nxt_out = gx[19:4];
        end
      end else begin
        nxt_bcnt = bcnt_ff + 3'h1;
        // bands A to E unless bypassed
        if (bcnt_ff != 3'h0 && !byp_ff[`B_EQBP]) begin
          nxt_eqx = hb;
        end
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_ff <= 1'b0;
      bcnt_ff <= 3'h0;
      eqx_ff <= 24'h00_0000;
      out_ff <= 16'h0000;
      ov_ff <= 1'b0;
      hx1_ff <= 24'h00_0000;
      hy1_ff <= 24'h00_0000;
      dy1_ff <= 24'h00_0000;
    end else if (ce) begin
      busy_ff <= nxt_busy;
      bcnt_ff <= nxt_bcnt;
      eqx_ff <= nxt_eqx;
      out_ff <= nxt_out;
      ov_ff <= nxt_ov;
      if (tick) begin
        hx1_ff <= xin;
        hy1_ff <= hp_o;
        dy1_ff <= de_y;
      end
    end
  end
  // Band delay states, one pair per band
  genvar gb;
  generate
    for (gb = 0; gb < 5; gb++) begin : g_band
      logic hit;
      assign hit = busy_ff && bcnt_ff == 3'(gb + 1) && !byp_ff[`B_EQBP];
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          d1_ff[gb] <= 24'h00_0000;
          d2_ff[gb] <= 24'h00_0000;
        end else if (ce && hit) begin
          d1_ff[gb] <= u;
          d2_ff[gb] <= p;
        end
      end
    end
  endgenerate

  assign reg_rdata = rd_ff;
  assign audio_out = out_ff;
  assign audio_valid = ov_ff;
  assign amp_on = amp_ff;
  assign pll_ref_sel = act_ff;
endmodule

// ===== bench/afe_top_assertions.sv
// Port-level checks for the audio front end
`timescale 1ns/1ps
module afe_top_assertions (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] audio_out,
  input wire logic audio_valid,
  input wire logic amp_on,
  input wire logic pll_ref_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Read side of the register port
  a_unmapped_zero: assert property (
    $past(reg_addr) inside {8'h02, 8'h04, [8'h09:8'h0f], [8'h1a:8'hff]}
    |-> reg_rdata == 16'h0000
  ) else $error("unmapped address read nonzero");
  a_eq_write_only: assert property (
    $past(reg_addr) inside {[8'h10:8'h19]} |-> reg_rdata == 16'h0000
  ) else $error("coefficient word read back nonzero");
  a_hpf_readback: assert property (
    reg_wr && reg_addr == 8'h06 ##1 reg_addr == 8'h06 && !reg_wr
    |=> reg_rdata == {7'h00, $past(reg_wdata[8:0], 2)}
  ) else $error("high-pass setting read back wrong");
  a_deemph_readback: assert property (
    reg_wr && reg_addr == 8'h07 ##1 reg_addr == 8'h07 && !reg_wr
    |=> reg_rdata == {14'h0000, $past(reg_wdata[1:0], 2)}
  ) else $error("de-emphasis field read back wrong");
  a_stat_onehot: assert property (
    $past(reg_addr) == 8'h08 && !$past(srst) |-> $onehot(reg_rdata[11:8])
  ) else $error("switch state not one-hot");

  // Output stream and switchover
  a_valid_spacing: assert property (
    audio_valid |=> !audio_valid [*7]
  ) else $error("samples closer than the band pipeline");
  a_out_stands: assert property (
    !audio_valid |-> $stable(audio_out)
  ) else $error("audio output moved without a valid");
  a_swap_while_off: assert property (
    $changed(pll_ref_sel) |-> !amp_on || !$past(amp_on)
  ) else $error("input swapped while amplifier on");
  a_off_brief: assert property (
    $fell(amp_on) && !$past(reg_wr) && !$past(reg_wr, 2) |-> ##[1:3] amp_on
  ) else $error("amplifier not back after swap");
endmodule

// ===== bench/serial_src.sv
// Behavioural serial audio source: I2S words or PCM slot frames
`timescale 1ns/1ps
module serial_src (
  input wire logic en,
  input wire logic pcm,
  input wire logic w16,
  input wire logic [4:0] slots,
  input wire logic [15:0] left,
  input wire logic [15:0] right,
  output logic sck,
  output logic ws,
  output logic sd
);
  logic [31:0] frame;
  logic mode;
  int n;

  // Bit clock only runs inside frames; idle data line keeps flipping
  initial begin
    sck = 1'b0;
    ws = 1'b0;
    sd = 1'b0;
    #7;
    forever begin
      if (!en) begin
        sck = 1'b0;
        sd = ~sd;
        #160;
      end else begin
        mode = pcm;
        n = mode ? slots * (w16 ? 16 : 8) : 32;
        frame = (mode && !w16) ? {left[15:8], right[15:8], 16'h0000}
                               : {left, right};
        for (int i = 0; i < n; i++) begin
          sck = 1'b0;
          ws = mode ? (i == n - 1) : (i >= 15 && i < 31);
          sd = (i < 32) ? frame[31 - i] : ~sd;
          #160;
          sck = 1'b1;
          #160;
        end
      end
    end
  end
endmodule

// ===== bench/tb_afe_top.sv
// Self-checking bench for the audio front end
`timescale 1ns/1ps
module tb_afe_top;
  localparam logic [15:0] dc = 16'h4000;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic [15:0] reg_rdata, audio_out, last_out;
  logic audio_valid, amp_on, pll_ref_sel;
  logic sck1, ws1, sd1, sck2, ws2, sd2;
  logic en = 1'b0;
  logic pcm2 = 1'b0;
  logic w16_2 = 1'b1;
  logic [4:0] slots2 = 5'h02;
  logic [15:0] l1 = 16'h0000, r1 = 16'h0000, r2 = 16'h0000;
  logic [15:0] seed = 16'h003e;
  int n_mismatch = 0;
  int num_checks = 0;
  int cnt;
  int n_off = 0;

  always #20 ref_clk = ~ref_clk;

  // Cycles spent in Off mode before the active input shows swapped
  always @(negedge ref_clk) begin
    if (en && amp_on === 1'b0 && pll_ref_sel === 1'b0) begin
      n_off++;
    end
  end

  afe_top i_dut (.ref_clk(ref_clk), .srst(srst), .ce(1'b1),
    .bit_clk1(sck1), .word_select_line1(ws1), .serial_audio_in1(sd1),
    .bit_clk2(sck2), .word_select_line2(ws2), .serial_audio_in2(sd2),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .audio_out(audio_out),
    .audio_valid(audio_valid), .amp_on(amp_on), .pll_ref_sel(pll_ref_sel));
  serial_src i_src1 (.en(en), .pcm(1'b0), .w16(1'b1), .slots(5'h02),
    .left(l1), .right(r1), .sck(sck1), .ws(ws1), .sd(sd1));
  serial_src i_src2 (.en(en), .pcm(pcm2), .w16(w16_2), .slots(slots2),
    .left(16'h0000), .right(r2), .sck(sck2), .ws(ws2), .sd(sd2));

  // Compare with a tolerance; zero tolerance is an exact match
  task automatic near(input logic [15:0] got, input int e, input int tol);
    num_checks++;
    if ($isunknown(got) || $signed(got) > e + tol || $signed(got) < e - tol)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %0d expected %0d", $time, got, e);
    end
  endtask
  function automatic int pick(input logic [15:0] l, input logic [15:0] r,
                              input int p);
    if (p == 0) return int'($signed(l));
    if (p == 1) return int'($signed(r));
    return (int'($signed(l)) + int'($signed(r))) >>> 1;
  endfunction
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input int e);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    near(reg_rdata & m, e, 0);
  endtask
  // Wait for n output samples, keeping the last
  task automatic samples(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge ref_clk);
        k++;
      end while (audio_valid !== 1'b1 && k < 2000);
      if (k >= 2000) begin
        n_mismatch++;
        $display("mismatch at %0t: no output sample", $time);
      end
      last_out = audio_out;
    end
    @(posedge ref_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #4_000_000;
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(8'h00, 16'hffff, 2);
    rd(8'h08, 16'h1f00, 16'h0100);
    rd(8'h05, 16'hffff, 2);
    rd(8'h01, 16'hffff, 0);
    rd(8'h20, 16'hffff, 0);
    wr(8'h10, 16'h1234);
    rd(8'h10, 16'hffff, 0);
    wr(8'h06, 16'h01ff);
    rd(8'h06, 16'hffff, 511);
    for (int d = 3; d >= 0; d--) begin
      wr(8'h07, 16'(d));
      rd(8'h07, 16'hffff, d);
    end
    en <= 1'b1;
    wr(8'h05, 16'h0003);
    for (int p = 0; p < 4; p++) begin
      seed = lfsr(seed);
      l1 <= seed;
      seed = lfsr(seed);
      r1 <= seed;
      wr(8'h01, 16'(p << 2));
      samples(3);
      near(last_out, pick(l1, r1, p), p / 2);
    end
    l1 <= dc;
    wr(8'h01, 16'h0000);
    wr(8'h05, 16'h0002);
    wr(8'h06, 16'h0000);
    samples(4);
    near(last_out, dc, 0);
    wr(8'h06, 16'h01ff);
    samples(16);
    near(last_out, 0, dc / 4);
    wr(8'h05, 16'h0003);
    wr(8'h07, 16'h0003);
    samples(24);
    near(last_out, dc, 4);
    l1 <= 16'h0000;
    samples(4);
    near(last_out, dc / 2, dc / 2 - dc / 16);
    wr(8'h07, 16'h0000);
    l1 <= dc;
    // Unity bands, then scale flags added band by band from A
    for (int b = 0; b < 6; b++) begin
      for (int i = 0; i < 5; i++) begin
        wr(8'h10 + 8'(2 * i), 16'h0000);
        wr(8'h11 + 8'(2 * i), i < b ? 16'h0041 : 16'h0040);
      end
      // Bands go live only once every word is defined
      if (b == 0) begin
        wr(8'h05, 16'h0001);
      end
      samples(4);
      near(last_out, dc >> b, 2);
    end
    wr(8'h05, 16'h0003);
    seed = lfsr(seed);
    r2 <= seed;
    wr(8'h03, 16'h0004);
    wr(8'h00, 16'h0003);
    rd(8'h08, 16'h1f00, 16'h0200);
    cnt = 0;
    while (pll_ref_sel === 1'b0 && cnt < 300) begin
      samples(1);
      cnt++;
    end
    near(16'(cnt), 128, 1);
    near(last_out, 0, dc / 32);
    near(16'(n_off), 1, 0);
    repeat (4) @(posedge ref_clk);
    near(16'(pll_ref_sel), 1, 0);
    near(16'(amp_on), 1, 0);
    samples(132);
    rd(8'h08, 16'h1f00, 16'h1100);
    near(last_out, pick(16'h0000, r2, 1), 0);
    // Slot count on the second input in both word widths
    for (int v = 0; v < 2; v++) begin
      pcm2 <= 1'b1;
      w16_2 <= (v == 0);
      slots2 <= (v == 0) ? 5'h03 : 5'h04;
      wr(8'h03, (v == 0) ? 16'h0007 : 16'h0005);
      samples(4);
      rd(8'h08, 16'h00ff, v + 3);
      near(last_out, pick(16'h0000,
        (v == 0) ? r2 : {r2[15:8], 8'h00}, 1), 0);
    end
    stop_test();
  end
endmodule

bind afe_top afe_top_assertions i_chk (.ref_clk(ref_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .audio_out(audio_out),
  .audio_valid(audio_valid), .amp_on(amp_on), .pll_ref_sel(pll_ref_sel));
